// [shared/pbcsr_pkg.sv]
// shared constants of the phy management register bank
package pbcsr_pkg;

  // index and data widths
  localparam int unsigned IDX_W  = 5;
  localparam int unsigned DATA_W = 16;

  // register indexes handled inside the bank
  localparam logic [4:0] IDX_BCTL  = 5'h00;
  localparam logic [4:0] IDX_BSTAT = 5'h01;
  localparam logic [4:0] IDX_PHYID = 5'h02;

  // one bit per index: 0..6, 17, 18, 27, 29, 30, 31 exist
  localparam logic [31:0] IDX_IMPL_MASK = 32'he806_007f;

  // basic control field positions
  localparam int unsigned BC_SRST   = 15;
  localparam int unsigned BC_LOOP   = 14;
  localparam int unsigned BC_SPEED  = 13;
  localparam int unsigned BC_ANEN   = 12;
  localparam int unsigned BC_PDN    = 11;
  localparam int unsigned BC_ANRST  = 9;
  localparam int unsigned BC_DUPLEX = 8;
  localparam int unsigned BC_COLT   = 7;

  // writable control bits, reserved bits read zero
  localparam logic [15:0] BCTL_WMASK = 16'hfb80;
  localparam logic [15:0] BCTL_RST   = 16'h0000;

  // basic status field positions
  localparam int unsigned BS_ANDONE = 5;
  localparam int unsigned BS_RFAULT = 4;
  localparam int unsigned BS_LINK   = 2;
  localparam int unsigned BS_JAB    = 1;

  // fixed status bits: abilities 14..11, an ability 3, extended 0
  localparam logic [15:0] BS_FIXED = 16'h7809;

  // latched status bits: remote fault, link, jabber
  localparam int unsigned NLATCH = 3;
  localparam logic [2:0]  LATCH_HIGH_MASK = 3'h5; // 0 jabber, 1 link, 2 fault
  localparam logic [15:0] ZERO16 = 16'h0000;

  // soft reset duration, at least this long
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SRST_TIME_NS  = 1000;
  localparam int unsigned SRST_CYCLES   =
    (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bank states
  typedef enum logic [0:0] {ST_RUN, ST_SRST} pbcsr_state_t;

endpackage

// [shared/pbcsr_srst_if.sv]
`timescale 1ns/1ps
`default_nettype none
// soft reset request and progress between bank and timer
interface pbcsr_srst_if;
  logic start;
  logic busy;
  logic done;
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface
`default_nettype wire

// [logic/pbcsr_srst_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// holds the soft reset for a fixed number of cycles
module pbcsr_srst_timer #(
  parameter int unsigned CYC = 10
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // control side
  pbcsr_srst_if.tmr sr
);
  localparam int unsigned CW = $clog2(CYC + 1);

  logic [CW-1:0] cnt_r;
  logic          busy_r;
  logic          done_r;

  // count down while busy, a new start restarts the count
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (sr.start) begin
        cnt_r  <= CW'(CYC - 1);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r == '0) begin
          busy_r <= 1'b0;
          done_r <= 1'b1; // single cycle end mark
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

  assign sr.busy = busy_r;
  assign sr.done = done_r;
endmodule
`default_nettype wire

// [logic/pbcsr_latch_bit.sv]
`timescale 1ns/1ps
`default_nettype none
// latching status bit, cleared to the live level by a read
module pbcsr_latch_bit (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // behaviour
  input  wire logic hold_high,
  input  wire logic clr,
  input  wire logic cond,
  input  wire logic rd,
  output logic      value
);
  logic val_r;

  // a read reloads the live level, so an event in the read cycle stays
  always_ff @(posedge clk) begin
    if (rst) begin
      val_r <= 1'b0;
    end else if (ce) begin
      if (clr) begin
        val_r <= 1'b0;
      end else if (rd) begin
        val_r <= cond;
      end else if (hold_high) begin
        val_r <= val_r | cond;
      end else begin
        val_r <= val_r & cond;
      end
    end
  end

  assign value = val_r;
endmodule
`default_nettype wire

// [logic/phy_basic_control_status_regs.sv]
// What this block does
// - registers sit behind the indexed management port only, not the memory map
// - decimal index selects register; 0..6, 17, 18, 27, 29..31 exist
// - control bit 15 starts soft reset and clears itself when done
// - fields kept over soft reset keep values only for that reset
// - control bit 14 selects loopback, zero is normal operation
// - control bit 13 picks 100 or 10 Mbps, ignored with bit 12 set
// - control bit 12 enables auto-negotiation, overriding speed and duplex
// - bit 11 powers down; after clearing, completion shows in status bit 5
// - control bit 9 restarts auto-negotiation and clears itself
// - control bit 8 picks full or half duplex, ignored under autoneg
// - control bit 7 enables collision test, resets to zero
// - control bits 13 and 12 reset from the speed select strap
// - status 15 reads zero, 14..11 read one, 10..6 read zero
// - status bit 5 shows auto-negotiation complete
// - status bit 4 latches high on remote fault
// - status bit 3 always reads one
// - status bit 2 shows link, latching low
// - status bit 1 latches high on jabber
// - status bit 0 reads one for extended registers
// - identifier word one is read-only, holding unique id bits 3..18
`timescale 1ns/1ps
`default_nettype none
module phy_basic_control_status_regs
  import pbcsr_pkg::*;
#(
  // arbitrary identifier value, not tied to any maker
  parameter logic [15:0] PHY_ID1   = 16'h5a3c,
  // control bits that survive a soft reset
  parameter logic [15:0] KEEP_MASK = 16'h0000,
  parameter int unsigned SRST_CYC  = SRST_CYCLES
) (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // strap
  input  wire logic        speed_sel_strap,
  // indexed management access
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [4:0]  acc_index,
  input  wire logic [15:0] acc_wdata,
  output logic             acc_ready,
  output logic             acc_done,
  output logic [15:0]      acc_rdata,
  // higher indexes served by the rest of the phy
  output logic             ext_sel,
  output logic             ext_write,
  output logic [4:0]       ext_index,
  output logic [15:0]      ext_wdata,
  input  wire logic [15:0] ext_rdata,
  // live conditions from the phy core
  input  wire logic        an_complete,
  input  wire logic        an_speed_100,
  input  wire logic        an_full_duplex,
  input  wire logic        remote_fault,
  input  wire logic        link_up,
  input  wire logic        jabber,
  // controls to the phy core
  output logic             phy_soft_reset,
  output logic             loopback_en,
  output logic             speed_100,
  output logic             full_duplex,
  output logic             an_enable,
  output logic             an_restart,
  output logic             power_down,
  output logic             col_test_en
);

  // state and storage
  pbcsr_state_t      state_r;
  pbcsr_state_t      state_nxt;
  logic [15:0]       ctl_r;
  logic              strap_r;
  logic [15:0]       stat_w;
  logic [NLATCH-1:0] latch_cond;
  logic [NLATCH-1:0] latch_val;
  logic              take;
  logic              is_local;
  logic              is_impl;
  logic              wr_ctl;
  logic              rd_stat;
  logic              srst_go;
  logic [15:0]       ctl_reset_val;
  logic [15:0]       rd_mux;

  pbcsr_srst_if sr ();

  // taken only outside soft reset and with the clock enabled, so nothing leaks out
  assign acc_ready = (state_r == ST_RUN) & ~sr.busy;
  assign take      = acc_valid & acc_ready & ce;

  assign is_impl  = IDX_IMPL_MASK[acc_index];
  assign is_local = (acc_index == IDX_BCTL) |
                    (acc_index == IDX_BSTAT) |
                    (acc_index == IDX_PHYID);

  // reached only through the indexed port
  assign wr_ctl  = take & acc_write & (acc_index == IDX_BCTL);
  assign rd_stat = take & ~acc_write & (acc_index == IDX_BSTAT);

  // a write with bit 15 set starts the soft reset
  assign srst_go  = wr_ctl & acc_wdata[BC_SRST];
  assign sr.start = srst_go;

  // remaining implemented indexes pass through to the rest of the phy
  assign ext_sel   = take & is_impl & ~is_local;
  assign ext_write = acc_write;
  assign ext_index = acc_index;
  assign ext_wdata = acc_wdata;

  // strap is caught while reset is held, after the edge it stays fixed
  always_ff @(posedge clk) begin
    if (ce && rst) begin
      strap_r <= speed_sel_strap;
    end
  end

  // speed and autoneg enable reset from the strap
  always_comb begin
    ctl_reset_val = BCTL_RST;
    ctl_reset_val[BC_SPEED] = strap_r;
    ctl_reset_val[BC_ANEN]  = strap_r;
  end

  // bank state: run, or wait for the soft reset to finish
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (srst_go) begin
          state_nxt = ST_SRST;
        end
      end
      ST_SRST: begin
        if (sr.done) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_RUN;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // control register; hard reset loads strap values, soft reset
  // reloads all but the kept fields
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_r <= BCTL_RST;
      ctl_r[BC_SPEED] <= speed_sel_strap;
      ctl_r[BC_ANEN]  <= speed_sel_strap;
    end else if (ce) begin
      if (srst_go) begin
        // other bits in a reset write are dropped
        ctl_r <= (ctl_r & KEEP_MASK) | (ctl_reset_val & ~KEEP_MASK);
        ctl_r[BC_SRST] <= 1'b1;
      end else if (state_r == ST_SRST) begin
        // kept fields survive only this reset source
        ctl_r <= (ctl_r & KEEP_MASK) | (ctl_reset_val & ~KEEP_MASK);
        // bit 15 clears itself when the reset ends
        ctl_r[BC_SRST] <= ~sr.done;
      end else if (wr_ctl) begin
        ctl_r <= acc_wdata & BCTL_WMASK;
      end else begin
        // restart bit lives for one cycle only
        ctl_r[BC_ANRST] <= 1'b0;
      end
    end
  end

  // control outputs registered so the phy sees clean levels
  always_ff @(posedge clk) begin
    if (rst) begin
      phy_soft_reset <= 1'b0;
      loopback_en    <= 1'b0;
      power_down     <= 1'b0;
      col_test_en    <= 1'b0;
      an_enable      <= 1'b0;
      an_restart     <= 1'b0;
    end else if (ce) begin
      // phy held in reset while the bit reads one
      phy_soft_reset <= ctl_r[BC_SRST];
      loopback_en    <= ctl_r[BC_LOOP];
      power_down     <= ctl_r[BC_PDN];
      col_test_en    <= ctl_r[BC_COLT];
      an_enable      <= ctl_r[BC_ANEN];
      an_restart     <= ctl_r[BC_ANRST];
    end
  end

  // manual speed and duplex count only while autoneg is off
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_100   <= 1'b0;
      full_duplex <= 1'b0;
    end else if (ce) begin
      if (ctl_r[BC_ANEN]) begin
        // negotiated result overrides the manual bits
        speed_100   <= an_speed_100;
        full_duplex <= an_full_duplex;
      end else begin
        speed_100   <= ctl_r[BC_SPEED];
        full_duplex <= ctl_r[BC_DUPLEX];
      end
    end
  end

  // latched status conditions, in order jabber, link, fault
  assign latch_cond[0] = jabber;
  assign latch_cond[1] = link_up;
  assign latch_cond[2] = remote_fault;

  // one latch per bit, polarity from the mask
  for (genvar i = 0; i < NLATCH; i++) begin : g_latch
    pbcsr_latch_bit u_latch (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .hold_high (LATCH_HIGH_MASK[i]),
      .clr       (state_r == ST_SRST),
      .cond      (latch_cond[i]),
      .rd        (rd_stat),
      .value     (latch_val[i])
    );
  end

  // status word assembled from fixed and live bits
  always_comb begin
    // fixed ability bits, reserved read zero
    stat_w = BS_FIXED;
    // completion cannot show while powered down
    stat_w[BS_ANDONE] = an_complete & ~ctl_r[BC_PDN] & ctl_r[BC_ANEN];
    stat_w[BS_RFAULT] = latch_val[2];
    stat_w[BS_LINK]   = latch_val[1];
    stat_w[BS_JAB]    = latch_val[0];
  end

  // read data source by index
  always_comb begin
    rd_mux = ZERO16;
    case (acc_index)
      IDX_BCTL:  rd_mux = ctl_r;
      IDX_BSTAT: rd_mux = stat_w;
      IDX_PHYID: rd_mux = PHY_ID1;
      default: begin
        rd_mux = is_impl ? ext_rdata : ZERO16;
      end
    endcase
  end

  // answer registered one cycle after an access is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_done  <= 1'b0;
      acc_rdata <= ZERO16;
    end else if (ce) begin
      acc_done <= take;
      if (take && !acc_write) begin
        acc_rdata <= rd_mux;
      end
    end
  end

  // soft reset timing lives in its own counter
  pbcsr_srst_timer #(
    .CYC (SRST_CYC)
  ) u_srst (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .sr  (sr)
  );

endmodule
`default_nettype wire

// [tb/pbcsr_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the management port and core controls
module pbcsr_checker
  import pbcsr_pkg::*;
#(
  parameter logic [15:0] PHY_ID1 = 16'h0000
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  // management port
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic [4:0]  acc_index,
  input wire logic [15:0] acc_wdata,
  input wire logic        acc_ready,
  input wire logic        acc_done,
  input wire logic [15:0] acc_rdata,
  input wire logic        ext_sel,
  // core side
  input wire logic        an_speed_100,
  input wire logic        an_full_duplex,
  input wire logic        phy_soft_reset,
  input wire logic        an_enable,
  input wire logic        speed_100,
  input wire logic        full_duplex,
  input wire logic        an_restart
);
  localparam int SR_MAX = 40;
  logic tk, rd, wc;
  // taken access, taken read, taken control write
  assign tk = ce && acc_valid && acc_ready;
  assign rd = tk && !acc_write;
  assign wc = tk && acc_write && acc_index == IDX_BCTL;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_done_after_take: assert property (tk |=> acc_done)
    else $error("no done after a taken access");
  a_done_has_cause: assert property (acc_done |-> $past(tk))
    else $error("done without a taken access");
  a_ext_select: assert property (ext_sel == (tk && IDX_IMPL_MASK[acc_index] && acc_index > 5'h02))
    else $error("forwarded select wrong");
  a_unmapped_zero: assert property (rd && !IDX_IMPL_MASK[acc_index] |=> acc_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_ident_read: assert property (rd && acc_index == IDX_PHYID |=> acc_rdata == PHY_ID1)
    else $error("identifier read wrong");
  a_status_fixed: assert property (rd && acc_index == IDX_BSTAT |=> (acc_rdata & 16'hffc9) == 16'h7809)
    else $error("fixed status bits wrong");
  a_srst_refuse: assert property (wc && acc_wdata[15] |=> !acc_ready ##1 phy_soft_reset)
    else $error("soft reset not entered");
  a_srst_ends: assert property (wc && acc_wdata[15] |-> ##[2:SR_MAX] acc_ready)
    else $error("soft reset never ends");
  a_restart_pulse: assert property (wc && acc_wdata[9] && !acc_wdata[15] |-> ##[1:3] an_restart)
    else $error("no restart pulse");
  a_restart_once: assert property (an_restart |=> !an_restart)
    else $error("restart pulse too long");
  a_auto_override: assert property (an_enable |-> speed_100 == $past(an_speed_100) && full_duplex == $past(an_full_duplex))
    else $error("negotiated speed or duplex not used");
  c_srst: cover property (wc && acc_wdata[15]);
  c_restart: cover property (an_restart);
  c_ext_read: cover property (ext_sel && !acc_write);
endmodule
`default_nettype wire

// [tb/pbcsr_mgr_model.sv]
`timescale 1ns/1ps
`default_nettype none
// management side: one indexed access at a time, never through a memory map
module pbcsr_mgr_model (
  // clock
  input  wire logic        clk,
  // requests
  output logic             acc_valid,
  output logic             acc_write,
  output logic [4:0]       acc_index,
  output logic [15:0]      acc_wdata,
  // answers
  input  wire logic        acc_ready,
  input  wire logic        acc_done,
  input  wire logic [15:0] acc_rdata
);
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_index = 5'h00;
    acc_wdata = 16'h0000;
  end
  // indexed access only
  // request held until a ready edge; released lines show inverted data
  task automatic xfer(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
                      output logic [15:0] rdv, output logic ok);
    ok = 1'b0;
    rdv = 16'h0000;
    @(posedge clk);
    #1;
    acc_valid = 1'b1;
    acc_write = wr;
    acc_index = idx;
    acc_wdata = wd;
    // ready is looked at on the rising edge that takes the request
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge clk);
      ok = (acc_ready === 1'b1);
    end
    #1;
    acc_valid = 1'b0;
    acc_index = ~idx;
    acc_wdata = ~wd;
    // the answer stands in the cycle after the take
    @(posedge clk);
    ok = ok && (acc_done === 1'b1);
    rdv = acc_rdata;
    #1;
  endtask
endmodule
`default_nettype wire

// [tb/phy_basic_control_status_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_basic_control_status_regs_tb_top import pbcsr_pkg::*;;
  // identifier value is arbitrary
  localparam logic [15:0] ID = 16'h1e2d;
  logic        clk, rst, ce, speed_sel_strap, acc_valid, acc_write;
  logic        an_complete, an_speed_100, an_full_duplex;
  logic        remote_fault, link_up, jabber, acc_ready, acc_done, ext_sel;
  logic        loopback_en, speed_100, full_duplex, an_enable;
  logic        an_restart, power_down, col_test_en, ex, ext_write;
  logic [4:0]  acc_index, ext_index;
  logic [15:0] acc_wdata, acc_rdata, ext_rdata, ext_wdata, ext_reg, v;
  logic [5:0]  outs;
  int          n_mismatch, n_compared, k;
  // core controls gathered for one compare
  assign outs = {loopback_en, power_down, col_test_en, an_enable, speed_100, full_duplex};
  // rest of the phy: one shared register, read back mixed with the index
  always @(posedge clk) begin
    if (ext_sel && ext_write) ext_reg <= ext_wdata;
  end
  assign ext_rdata = ext_reg ^ {11'h000, ext_index};
  // loopback kept over soft reset so that the kept path is exercised
  phy_basic_control_status_regs #(.PHY_ID1(ID), .KEEP_MASK(16'h4000), .SRST_CYC(2)) u_dut (
    .clk, .rst, .ce, .speed_sel_strap, .acc_valid, .acc_write, .acc_index,
    .acc_wdata, .acc_ready, .acc_done, .acc_rdata, .ext_sel, .ext_write,
    .ext_index, .ext_wdata, .ext_rdata, .an_complete, .an_speed_100,
    .an_full_duplex, .remote_fault, .link_up, .jabber, .phy_soft_reset(),
    .loopback_en, .speed_100, .full_duplex, .an_enable, .an_restart,
    .power_down, .col_test_en);
  pbcsr_mgr_model u_mgr (.clk, .acc_valid, .acc_write, .acc_index, .acc_wdata,
    .acc_ready, .acc_done, .acc_rdata);
  always #50 clk = ~clk;
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // a refused or hung access ends the run
  task automatic acc(input logic wr, input logic [4:0] i, input logic [15:0] d);
    logic ok;
    u_mgr.xfer(wr, i, d, v, ok);
    if (!ok) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic rc(input logic [4:0] i, input logic [15:0] e);
    acc(1'b0, i, 16'h0000);
    chk($sformatf("rdata idx %0d", i), v, e);
  endtask
  task automatic hres(input logic s);
    rst = 1'b1;
    speed_sel_strap = s;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
  endtask
  // let the registered controls settle, then compare them
  task automatic outs_is(input logic [15:0] e);
    repeat (2) @(posedge clk);
    #1;
    chk("controls", 16'(outs), e);
  endtask
  initial begin
    {clk, ce, an_complete, an_speed_100, an_full_duplex} = 5'b01110;
    {remote_fault, link_up, jabber, n_mismatch, n_compared} = '0;
    link_up = 1'b1;
    ext_reg = 16'h3c5a;
    hres(1'b1);
    rc(IDX_BCTL, 16'h3000);
    outs_is(16'h0006);
    rc(IDX_BSTAT, 16'h7829);
    rc(IDX_BSTAT, 16'h782d);
    // short fault, jabber and link loss between two reads
    {jabber, remote_fault, link_up} = 3'b110;
    repeat (2) @(posedge clk);
    #1;
    {jabber, remote_fault, link_up} = 3'b001;
    rc(IDX_BSTAT, 16'h783b);
    rc(IDX_BSTAT, 16'h782d);
    // a jabber pulse while the clock enable is low must leave no trace
    ce = 1'b0;
    jabber = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    {ce, jabber} = 2'b10;
    rc(IDX_BSTAT, 16'h782d);
    rc(IDX_PHYID, ID);
    acc(1'b1, IDX_PHYID, 16'hffff);
    rc(IDX_PHYID, ID);
    acc(1'b1, IDX_BSTAT, 16'hffff);
    rc(IDX_BSTAT, 16'h782d);
    // every index above the bank: forwarded or reads zero
    for (int i = 3; i < 32; i++) begin
      ex = i <= 6 || i == 17 || i == 18 || i == 27 || i >= 29;
      rc(5'(i), ex ? (16'h3c5a ^ 16'(i)) : 16'h0000);
    end
    // a forwarded write reaches the rest of the phy, an unknown index is dropped
    acc(1'b1, 5'h04, 16'ha5a5);
    acc(1'b1, 5'h07, 16'hffff);
    rc(5'h04, 16'ha5a1);
    acc(1'b1, IDX_BCTL, 16'h6980);
    outs_is(16'h003b);
    rc(IDX_BCTL, 16'h6980);
    rc(IDX_BSTAT, 16'h780d);
    acc(1'b1, IDX_BCTL, 16'h0000);
    outs_is(16'h0000);
    {an_speed_100, an_full_duplex} = 2'b01;
    acc(1'b1, IDX_BCTL, 16'h3000);
    outs_is(16'h0005);
    acc(1'b1, IDX_BCTL, 16'h5200);
    k = 0;
    repeat (6) begin
      @(negedge clk);
      if (an_restart === 1'b1) k++;
    end
    chk("restart pulses", 16'(k), 16'h0001);
    rc(IDX_BCTL, 16'h5000);
    speed_sel_strap = 1'b0;
    acc(1'b1, IDX_BCTL, 16'h8000);
    rc(IDX_BCTL, 16'h7000);
    rc(IDX_BSTAT, 16'h7829);
    hres(1'b0);
    rc(IDX_BCTL, 16'h0000);
    outs_is(16'h0000);
    conclude();
  end
endmodule
bind phy_basic_control_status_regs pbcsr_checker #(.PHY_ID1(PHY_ID1)) u_chk (
  .clk, .rst, .ce, .acc_valid, .acc_write, .acc_index, .acc_wdata, .acc_ready,
  .acc_done, .acc_rdata, .ext_sel, .an_speed_100, .an_full_duplex,
  .phy_soft_reset, .an_enable, .speed_100, .full_duplex, .an_restart);
`default_nettype wire
